// file: logic/quad_pot_decoder.v
// Serial command decoder, wiper registers and preset stores of a quad pot.
// Assumes host pins are asynchronous to ref_clk_i and the serial clock is slow.
`timescale 1ns/10ps
`include "quad_pot_map.vh"

// How it works
// RQ1: Each pot holds four 6-bit preset stores readable and writable by host.
// RQ2: Store changes are nonvolatile writes finishing within 10 ms.
// RQ3: Store save begins only at select rise after a complete write.
// RQ4: Write-progress flag shows a running save, read by status command.
// RQ5: First byte after select fall is the identification byte.
// RQ6: Low two identification bits must match address straps to continue.
// RQ7: Host sends zero in the two middle identification bits.
// RQ8: Second byte: opcode, store select, pot select.
// RQ9: Opcode 1001 returns two zeros and the wiper position.
// RQ10: Opcode 1010 loads data byte low six bits into wiper.
// RQ11: Opcode 1011 returns the selected preset store.
// RQ12: Opcode 1100 writes data bits nonvolatilely into selected store.
// RQ13: Opcode 1101 copies selected store into the pot's wiper.
// RQ14: Opcode 1110 copies wiper nonvolatilely into chosen store.
// RQ15: Opcode 0001 copies chosen store into all four wipers.
// RQ16: Opcode 1000 saves all four wipers into chosen store.
// RQ17: Store-to-wiper copies take effect after a short response delay.
// RQ18: Opcode 0010 starts stepping lasting until select rises.
// RQ19: Clock pulse with input high steps wiper toward high terminal.
// RQ20: Clock pulse with input low steps wiper toward low terminal.
// RQ21: Status command 0101 0001 returns the write-progress flag.
// RQ22: Input sampled on rising clock; output shifted on falling clock.
// RQ23: Each wiper value decodes to exactly one of 64 tap enables.
// RQ24: At power-up each wiper loads from store zero.
// RQ25: Hold low with clock low pauses; sequence state is kept.
// RQ26: Stepping saturates at tap 63 and tap 0.
// RQ27: Identification mismatch ignores the rest; output stays undriven.
// RQ28: Unknown opcodes are ignored until the next select fall.
module quad_pot_decoder #(
  parameter NV_CYCLES = `NV_WRITE_TIME_MS * `CLK_KHZ,
  parameter RESP_CYCLES = 2
) (
  // Clock and reset
  input wire ref_clk_i,
  input wire rst_i,
  // Host serial pins
  input wire cs_n_i,
  input wire sck_i,
  input wire si_i,
  input wire hold_n_i,
  input wire [1:0] addr_strap_pins_i,
  output reg so_o,
  output reg so_oe_o,
  // Pot tap enables, one-hot per pot
  output reg [255:0] tap_en_o,
  // Status
  output reg write_progress_flag_o
);
  localparam ST_ID = 5'h01;
  localparam ST_INSTR = 5'h02;
  localparam ST_DATA = 5'h04;
  localparam ST_STEP = 5'h08;
  localparam ST_IGNORE = 5'h10;

  // Synchronisers
  reg [1:0] cs_s_q, sck_s_q, si_s_q, hold_s_q;
  reg [1:0] strap_a_q, strap_b_q;
  reg cs_d1_q, sck_d1_q;
  wire cs_n = cs_s_q[1];
  wire sck = sck_s_q[1];
  wire hold_n = hold_s_q[1];
  reg held_q;
  wire sck_rise = sck & ~sck_d1_q & ~held_q;
  wire sck_fall = ~sck & sck_d1_q & ~held_q;
  wire cs_fall = ~cs_n & cs_d1_q;
  wire cs_rise = cs_n & ~cs_d1_q;

  // Storage
  reg [5:0] wiper_q [0:3];
  reg [5:0] store_q [0:15];
  reg [4:0] state_q;
  reg [2:0] bit_q;
  reg [7:0] shift_q;
  reg [7:0] out_q;
  reg [3:0] op_q;
  reg [1:0] rsel_q, psel_q;
  reg pend_q;
  reg pend_glb_q;
  reg [5:0] pend_val_q;
  reg [3:0] pend_idx_q;
  reg boot_q;
  localparam [31:0] RESP_W = RESP_CYCLES;
  reg [3:0] xfer_mask_q;
  reg [1:0] xfer_rsel_q;
  reg [7:0] resp_cnt_q;
  wire [7:0] rx_byte = {shift_q[6:0], si_s_q[1]};
  wire nv_busy;
  reg nv_start_q;
  integer i;

  /////////////////////////////////////////////////////////////////////////////
  nv_write_timer #(
    .CYCLES(NV_CYCLES)
  ) u_nv_timer (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .start_i(nv_start_q),
    .busy_o(nv_busy),
    .done_o()
  );

  /////////////////////////////////////////////////////////////////////////////
  always @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cs_s_q <= 2'h3;
      sck_s_q <= 2'h0;
      si_s_q <= 2'h0;
      hold_s_q <= 2'h3;
      strap_a_q <= 2'h0;
      strap_b_q <= 2'h0;
      cs_d1_q <= 1'b1;
      sck_d1_q <= 1'b0;
      held_q <= 1'b0;
    end
    else
    begin
      cs_s_q <= {cs_s_q[0], cs_n_i};
      sck_s_q <= {sck_s_q[0], sck_i};
      si_s_q <= {si_s_q[0], si_i};
      hold_s_q <= {hold_s_q[0], hold_n_i};
      strap_a_q <= addr_strap_pins_i;
      strap_b_q <= strap_a_q;
      cs_d1_q <= cs_n;
      sck_d1_q <= sck;
      if (cs_n)
        held_q <= 1'b0;
      else if (!sck)
        held_q <= ~hold_n; // RQ25
    end
  end

  /////////////////////////////////////////////////////////////////////////////
  // Serial sequencer, register updates and store save
  always @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_q <= ST_IGNORE;
      bit_q <= 3'h0;
      shift_q <= 8'h0;
      out_q <= 8'h0;
      op_q <= 4'h0;
      rsel_q <= 2'h0;
      psel_q <= 2'h0;
      pend_q <= 1'b0;
      pend_glb_q <= 1'b0;
      pend_val_q <= 6'h0;
      pend_idx_q <= 4'h0;
      nv_start_q <= 1'b0;
      boot_q <= 1'b1;
      xfer_mask_q <= 4'h0;
      xfer_rsel_q <= 2'h0;
      resp_cnt_q <= 8'h0;
      so_o <= 1'b0;
      so_oe_o <= 1'b0;
      for (i = 0; i < 4; i = i + 1)
        wiper_q[i] <= 6'h0;
      for (i = 0; i < 16; i = i + 1)
        store_q[i] <= 6'h0;
    end
    else
    begin
      nv_start_q <= 1'b0;
      if (boot_q)
      begin
        boot_q <= 1'b0;
        for (i = 0; i < 4; i = i + 1)
          wiper_q[i] <= store_q[{2'h0, i[1:0]}]; // RQ24
      end
      // Delayed store-to-wiper load
      if (xfer_mask_q != 4'h0)
      begin
        if (resp_cnt_q == 8'h0)
        begin
          for (i = 0; i < 4; i = i + 1)
            if (xfer_mask_q[i])
              wiper_q[i] <= store_q[{xfer_rsel_q, i[1:0]}]; // RQ17
          xfer_mask_q <= 4'h0;
        end
        else
          resp_cnt_q <= resp_cnt_q - 8'h1;
      end
      if (cs_n)
      begin
        so_oe_o <= 1'b0;
        state_q <= ST_IGNORE;
        if (cs_rise && pend_q && !nv_busy)
        begin
          pend_q <= 1'b0;
          nv_start_q <= 1'b1; // RQ3
          if (pend_glb_q)
            for (i = 0; i < 4; i = i + 1)
              store_q[{pend_idx_q[3:2], i[1:0]}] <= wiper_q[i]; // RQ16
          else
            store_q[pend_idx_q] <= pend_val_q; // RQ2
        end
        else if (cs_rise)
          pend_q <= 1'b0;
      end
      else if (cs_fall)
      begin
        state_q <= ST_ID; // RQ5
        bit_q <= 3'h0;
        pend_q <= 1'b0;
      end
      else if (sck_rise)
      begin // RQ22
        shift_q <= rx_byte;
        bit_q <= bit_q + 3'h1;
        case (state_q)
          ST_ID:
            if (bit_q == `BIT_LAST)
              state_q <= (rx_byte[1:0] == strap_b_q) ? ST_INSTR : ST_IGNORE; // RQ6 RQ27
          ST_INSTR:
            if (bit_q == `BIT_LAST)
            begin // RQ8
              op_q <= rx_byte[7:4];
              rsel_q <= rx_byte[3:2];
              psel_q <= rx_byte[1:0];
              state_q <= ST_IGNORE;
              case (rx_byte[7:4])
                `OP_RD_WIPER:
                  if (rx_byte[3:2] == `FIELDS_ZERO)
                  begin
                    out_q <= {2'h0, wiper_q[rx_byte[1:0]]}; // RQ9
                    state_q <= ST_DATA;
                  end
                `OP_WR_WIPER:
                  if (rx_byte[3:2] == `FIELDS_ZERO)
                    state_q <= ST_DATA;
                `OP_RD_STORE:
                begin
                  out_q <= {2'h0, store_q[rx_byte[3:0]]}; // RQ11 RQ1
                  state_q <= ST_DATA;
                end
                `OP_WR_STORE:
                  state_q <= ST_DATA;
                `OP_STORE_TO_WIPER:
                begin
                  xfer_mask_q <= 4'h1 << rx_byte[1:0]; // RQ13
                  xfer_rsel_q <= rx_byte[3:2];
                  resp_cnt_q <= RESP_W[7:0];
                end
                `OP_WIPER_TO_STORE:
                begin
                  pend_q <= 1'b1; // RQ14
                  pend_glb_q <= 1'b0;
                  pend_idx_q <= rx_byte[3:0];
                  pend_val_q <= wiper_q[rx_byte[1:0]];
                end
                `OP_GLB_STORE_TO_WIPER:
                  if (rx_byte[1:0] == `FIELDS_ZERO)
                  begin
                    xfer_mask_q <= 4'hf; // RQ15
                    xfer_rsel_q <= rx_byte[3:2];
                    resp_cnt_q <= RESP_W[7:0];
                  end
                `OP_GLB_WIPER_TO_STORE:
                  if (rx_byte[1:0] == `FIELDS_ZERO)
                  begin
                    pend_q <= 1'b1; // RQ16
                    pend_glb_q <= 1'b1;
                    pend_idx_q <= {rx_byte[3:2], 2'h0};
                  end
                `OP_STEP:
                  if (rx_byte[3:2] == `FIELDS_ZERO)
                    state_q <= ST_STEP; // RQ18
                `OP_STATUS:
                  if (rx_byte[3:0] == `FIELDS_STATUS)
                  begin
                    out_q <= {7'h0, nv_busy}; // RQ21 RQ4
                    state_q <= ST_DATA;
                  end
                default:
                  state_q <= ST_IGNORE; // RQ28
              endcase
            end
          ST_DATA:
            if (bit_q == `BIT_LAST)
            begin
              state_q <= ST_IGNORE;
              if (op_q == `OP_WR_WIPER)
                wiper_q[psel_q] <= rx_byte[5:0]; // RQ10
              else if (op_q == `OP_WR_STORE)
              begin
                pend_q <= 1'b1; // RQ12
                pend_glb_q <= 1'b0;
                pend_idx_q <= {rsel_q, psel_q};
                pend_val_q <= rx_byte[5:0];
              end
            end
          ST_STEP:
            if (si_s_q[1])
            begin
              if (wiper_q[psel_q] != `TAP_MAX)
                wiper_q[psel_q] <= wiper_q[psel_q] + 6'h1; // RQ19 RQ26
            end
            else if (wiper_q[psel_q] != `TAP_MIN)
              wiper_q[psel_q] <= wiper_q[psel_q] - 6'h1; // RQ20 RQ26
          default:
            state_q <= ST_IGNORE;
        endcase
      end
      else if (sck_fall)
      begin
        if (state_q == ST_DATA && op_q != `OP_WR_WIPER && op_q != `OP_WR_STORE)
        begin
          so_oe_o <= 1'b1; // RQ22
          so_o <= out_q[`BIT_LAST - bit_q];
        end
        else
          so_oe_o <= 1'b0; // RQ27
      end
    end
  end

  /////////////////////////////////////////////////////////////////////////////
  // Tap decode and status outputs
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : g_tap
      always @(posedge ref_clk_i or posedge rst_i)
      begin
        if (rst_i)
          tap_en_o[g*64 +: 64] <= 64'h1;
        else
          tap_en_o[g*64 +: 64] <= 64'h1 << wiper_q[g]; // RQ23
      end
    end
  endgenerate

  always @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      write_progress_flag_o <= 1'b0;
    else
      write_progress_flag_o <= nv_busy; // RQ4
  end
endmodule

// file: logic/quad_pot_map.vh
// Constants for the quad pot serial command decoder.
// Included by the decoder and the bench; holds definitions only.
`ifndef QUAD_POT_MAP_VH
`define QUAD_POT_MAP_VH
`define OP_RD_WIPER 4'h9
`define OP_WR_WIPER 4'ha
`define OP_RD_STORE 4'hb
`define OP_WR_STORE 4'hc
`define OP_STORE_TO_WIPER 4'hd
`define OP_WIPER_TO_STORE 4'he
`define OP_GLB_STORE_TO_WIPER 4'h1
`define OP_GLB_WIPER_TO_STORE 4'h8
`define OP_STEP 4'h2
`define OP_STATUS 4'h5
`define FIELDS_STATUS 4'h1
`define FIELDS_ZERO 2'h0
`define TAP_MAX 6'h3f
`define TAP_MIN 6'h00
`define BIT_LAST 3'h7
`define NV_WRITE_TIME_MS 10
`define CLK_KHZ 10000
`endif

// file: logic/nv_write_timer.v
// Nonvolatile write timer: holds busy for a fixed count after a start pulse.
// Assumes start_i is a one-cycle pulse on the same clock.
`timescale 1ns/10ps
module nv_write_timer #(
  parameter CYCLES = 100000
) (
  // Clock and reset
  input wire ref_clk_i,
  input wire rst_i,
  // Control
  input wire start_i,
  output reg busy_o,
  output reg done_o
);
  reg [31:0] cnt_q;

  always @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cnt_q <= 32'h0;
      busy_o <= 1'b0;
      done_o <= 1'b0;
    end
    else
    begin
      done_o <= 1'b0;
      if (start_i)
      begin
        cnt_q <= CYCLES - 1;
        busy_o <= 1'b1;
      end
      else if (busy_o)
      begin
        if (cnt_q == 32'h0)
        begin
          busy_o <= 1'b0;
          done_o <= 1'b1;
        end
        else
        begin
          cnt_q <= cnt_q - 32'h1;
        end
      end
    end
  end
endmodule

// file: dv/quad_pot_decoder_sva.sv
// Port checker for the quad pot decoder.
// Assumes one clock domain; bound to every decoder instance.
`timescale 1ns/10ps
module quad_pot_decoder_sva #(
  parameter NV_CYCLES = 100000,
  parameter RESP_CYCLES = 2
) (
  // Clock and reset
  input wire ref_clk_i,
  input wire rst_i,
  // Host pins
  input wire cs_n_i,
  input wire sck_i,
  input wire si_i,
  input wire hold_n_i,
  input wire [1:0] addr_strap_pins_i,
  input wire so_o,
  input wire so_oe_o,
  // Pot side
  input wire [255:0] tap_en_o,
  input wire write_progress_flag_o
);
  int busy_q;
  int idle_q;
  always @(posedge ref_clk_i or posedge rst_i)
    if (rst_i)
    begin
      busy_q <= 0;
      idle_q <= 0;
    end
    else
    begin
      busy_q <= write_progress_flag_o ? busy_q + 1 : 0;
      idle_q <= !cs_n_i ? 0 : (idle_q < 20 ? idle_q + 1 : idle_q);
    end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  a_tap_onehot: assert property ($onehot(tap_en_o[63:0]) && $onehot(tap_en_o[127:64])
    && $onehot(tap_en_o[191:128]) && $onehot(tap_en_o[255:192])) else $error("tap bad");
  a_save_max: assert property (write_progress_flag_o |-> busy_q <= NV_CYCLES + 1)
    else $error("save long");
  a_save_min: assert property ($fell(write_progress_flag_o) |-> busy_q >= NV_CYCLES - 1)
    else $error("save short");
  a_save_on_cs: assert property ($rose(write_progress_flag_o) |-> cs_n_i && $past(cs_n_i))
    else $error("save early");
  a_hold_keeps: assert property ((!hold_n_i) [*4] |-> $stable(tap_en_o))
    else $error("hold moved");
  a_idle_keeps: assert property (idle_q >= 12 |-> $stable(tap_en_o))
    else $error("late move");
  a_oe_start_sel: assert property ($rose(so_oe_o) |-> !cs_n_i)
    else $error("drive unselected");
  a_oe_idle_off: assert property (idle_q >= 6 |-> !so_oe_o)
    else $error("drive idle");
  c_save: cover property ($rose(write_progress_flag_o));
  c_read: cover property ($rose(so_oe_o));
  c_hold: cover property (!hold_n_i);
  c_step: cover property (!cs_n_i && $changed(tap_en_o));
endmodule
bind quad_pot_decoder quad_pot_decoder_sva #(.NV_CYCLES(NV_CYCLES), .RESP_CYCLES(RESP_CYCLES))
  quad_pot_decoder_sva_inst (.ref_clk_i, .rst_i, .cs_n_i, .sck_i, .si_i, .hold_n_i,
  .addr_strap_pins_i, .so_o, .so_oe_o, .tap_en_o, .write_progress_flag_o);

// file: dv/host.sv
// Host model: bus master on select, serial clock, data and hold.
// Assumes the bench calls its tasks; serial clock idles low outside frames.
`timescale 1ns/10ps
module host (
  // Clock and returned data
  input wire ref_clk_i,
  input wire so_i,
  // Host pins
  output reg cs_n_o = 1'b1,
  output reg sck_o = 1'b0,
  output reg si_o = 1'b0,
  output reg hold_n_o = 1'b1
);
  task automatic gap(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask
  task automatic sh(input logic [7:0] tx, input int n, output logic [7:0] rx);
    for (int i = 7; i > 7 - n; i--)
    begin
      gap(1);
      cs_n_o = 0;
      sck_o = 0;
      si_o = tx[i];
      gap(4);
      rx[i] = so_i;
      sck_o = 1;
      gap(3);
    end
  endtask
  task automatic pause();
    gap(1);
    sck_o = 0;
    si_o = 1;
    gap(4);
    hold_n_o = 0;
    repeat (2)
    begin
      gap(4);
      sck_o = 1;
      gap(4);
      sck_o = 0;
    end
    gap(4);
    hold_n_o = 1;
  endtask
  task automatic stop();
    gap(4);
    sck_o = 0;
    gap(4);
    cs_n_o = 1;
    si_o = ~si_o;
    gap(16);
  endtask
endmodule

// file: dv/tb.sv
// Bench for the quad pot decoder driven by the host model.
// Assumes stores start at zero and the checker is bound.
`timescale 1ns/10ps
`include "quad_pot_map.vh"
`define CHK(g, e) compares++; if ((g) !== (e)) miss();
module tb;
  localparam logic [3:0] DEV_TYPE = 4'h3; // Arbitrary value
  logic ref_clk_i = 0;
  logic rst_i = 1;
  logic [1:0] addr_strap_pins_i = 2'h0;
  wire cs_n_i, sck_i, si_i, hold_n_i, so_o, so_oe_o, write_progress_flag_o;
  wire [255:0] tap_en_o;
  logic [5:0] wpos [4];
  logic [5:0] nvs [16];
  logic [3:0] bad [5] = '{4'h3, 4'h4, 4'h6, 4'h7, 4'hf};
  logic [7:0] rx, d;
  logic [1:0] a, r;
  logic oe_seen = 0;
  int seed = 59977;
  int mismatches = 0;
  int compares = 0;
  initial forever #50 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) if (so_oe_o) oe_seen <= 1;
  quad_pot_decoder #(.NV_CYCLES(400), .RESP_CYCLES(2)) quad_pot_decoder_inst (.ref_clk_i,
    .rst_i, .cs_n_i, .sck_i, .si_i, .hold_n_i, .addr_strap_pins_i, .so_o, .so_oe_o,
    .tap_en_o, .write_progress_flag_o);
  // Undriven output shows the inverse of its last value, so a missing enable fails reads
  host host_inst (.ref_clk_i, .so_i(so_oe_o ? so_o : ~so_o), .cs_n_o(cs_n_i), .sck_o(sck_i),
    .si_o(si_i),
    .hold_n_o(hold_n_i));
  task automatic miss();
    mismatches++;
    $display("unexpected at %0t: value mismatch", $time);
  endtask
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  function automatic logic [255:0] taps();
    logic [255:0] v;
    v = '0;
    for (int p = 0; p < 4; p++) v[p * 64 + wpos[p]] = 1'b1;
    return v;
  endfunction
  task automatic cmd(input logic [1:0] id, input logic [7:0] ins, input logic [7:0] dt,
    input int nb);
    host_inst.sh({DEV_TYPE, 2'b00, id}, 8, rx);
    host_inst.sh(ins, 8, rx);
    if (nb > 16) host_inst.sh(dt, nb - 16, rx);
    host_inst.stop();
  endtask
  task automatic idle();
    int n;
    for (n = 0; n < 600 && write_progress_flag_o !== 1'b0; n++) @(negedge ref_clk_i);
    if (n == 600) miss();
    if (n == 600) wrap_up();
  endtask
  task automatic rd_store(input logic [3:0] i);
    cmd(a, {`OP_RD_STORE, i}, 8'h00, 24);
    `CHK(rx, ({2'b00, nvs[i]}))
  endtask
  task automatic step(input logic [1:0] p, input logic [5:0] w0, input logic [7:0] up,
    input int nu, input int nd, input logic [5:0] e);
    wpos[p] = e;
    cmd(a, {`OP_WR_WIPER, 2'b00, p}, {2'b00, w0}, 24);
    host_inst.sh({DEV_TYPE, 2'b00, a}, 8, rx);
    host_inst.sh({`OP_STEP, 2'b00, p}, 8, rx);
    host_inst.sh(up, nu, rx);
    host_inst.pause();
    host_inst.sh(8'h00, nd, rx);
    host_inst.stop();
    `CHK(tap_en_o, taps())
  endtask
  initial
  begin
    a = 2'($random(seed));
    addr_strap_pins_i = a;
    repeat (6) @(negedge ref_clk_i);
    rst_i = 0;
    repeat (6) @(negedge ref_clk_i);
    foreach (wpos[p]) wpos[p] = 0;
    foreach (nvs[i]) nvs[i] = 0;
    `CHK(tap_en_o, taps())
    for (int p = 0; p < 4; p++)
    begin
      d = 8'($random(seed));
      wpos[p] = d[5:0];
      cmd(a, {`OP_WR_WIPER, 2'b00, p[1:0]}, d, 24);
      cmd(a, {`OP_RD_WIPER, 2'b00, p[1:0]}, 8'h00, 24);
      `CHK(rx, ({2'b00, wpos[p]}))
    end
    `CHK(tap_en_o, taps())
    r = 2'($random(seed));
    cmd(a, {`OP_GLB_WIPER_TO_STORE, r, 2'b00}, 8'h00, 16);
    idle();
    for (int p = 0; p < 4; p++) nvs[{r, p[1:0]}] = wpos[p];
    for (int p = 0; p < 4; p++) rd_store({r, p[1:0]});
    $display("test wiper access ends");
    for (int i = 0; i < 16; i++)
    begin
      d = 8'($random(seed));
      nvs[i] = d[5:0];
      cmd(a, {`OP_WR_STORE, 4'(i)}, d, 24);
      cmd(a, {`OP_STATUS, `FIELDS_STATUS}, 8'h00, 24);
      `CHK(rx, 8'h01)
      idle();
      rd_store(4'(i));
    end
    cmd(a, {`OP_STATUS, `FIELDS_STATUS}, 8'h00, 24);
    `CHK(rx, 8'h00)
    cmd(a, {`OP_WR_STORE, 4'h5}, ~{2'b00, nvs[5]}, 20);
    `CHK(write_progress_flag_o, 1'b0)
    rd_store(4'h5);
    $display("test store access ends");
    for (int p = 0; p < 4; p++)
    begin
      r = 2'($random(seed));
      wpos[p] = nvs[{r, p[1:0]}];
      cmd(a, {`OP_STORE_TO_WIPER, r, p[1:0]}, 8'h00, 16);
    end
    `CHK(tap_en_o, taps())
    r = 2'($random(seed));
    for (int p = 0; p < 4; p++) wpos[p] = nvs[{r, p[1:0]}];
    cmd(a, {`OP_GLB_STORE_TO_WIPER, r, 2'b00}, 8'h00, 16);
    `CHK(tap_en_o, taps())
    `CHK(write_progress_flag_o, 1'b0)
    nvs[14] = wpos[2];
    cmd(a, {`OP_WIPER_TO_STORE, 4'he}, 8'h00, 16);
    `CHK(write_progress_flag_o, 1'b1)
    idle();
    rd_store(4'he);
    $display("test copies ends");
    step(2'h1, 6'h3e, 8'hff, 3, 5, 6'h3a);
    step(2'h2, 6'h01, 8'h80, 2, 3, 6'h00);
    $display("test stepping ends");
    oe_seen = 0;
    for (int k = 1; k < 4; k++) cmd(a ^ 2'(k), {`OP_RD_WIPER, 4'h0}, 8'h00, 24);
    cmd(a ^ 2'h2, {`OP_WR_WIPER, 4'h0}, 8'h15, 24);
    `CHK(oe_seen, 1'b0)
    foreach (bad[k]) cmd(a, {bad[k], 4'h0}, 8'h15, 24);
    `CHK(tap_en_o, taps())
    `CHK(write_progress_flag_o, 1'b0)
    $display("test refusals ends");
    wrap_up();
  end
endmodule
